// file: hdl/swsc_pkg.sv
/*
  Package for the serial write and slew control block: register offsets,
  field positions, reset values and the slew timing tables.
  Assumes a 10 MHz system clock; the slew rate divider counts below are derived from it.
*/
package swsc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int CODE_W = 16;

  // Serial frame layout
  localparam int FRAME_LONG = 32;
  localparam int FRAME_SHORT = 24;
  localparam int F_CHECK = 31;
  localparam int F_BADDR_HI = 30;
  localparam int F_BADDR_LO = 29;
  localparam int F_RADDR_HI = 28;
  localparam int F_RADDR_LO = 24;
  localparam int F_DATA_HI = 23;
  localparam int F_DATA_LO = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;

  // Register addresses carried in serial frames
  localparam logic [4:0] RA_TARGET = 5'h01;
  localparam logic [4:0] RA_CLEAR = 5'h02;
  localparam logic [4:0] RA_GEN = 5'h03;
  localparam logic [4:0] RA_SLEW = 5'h04;

  // Byte offsets on the local register port
  localparam logic [4:0] OFS_GEN = 5'h00;
  localparam logic [4:0] OFS_SLEW = 5'h04;
  localparam logic [4:0] OFS_TARGET = 5'h08;
  localparam logic [4:0] OFS_CLEAR = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_MASK = 5'h14;
  localparam logic [4:0] OFS_CODE = 5'h18;
  localparam logic [4:0] OFS_FRAME = 5'h1c;

  // general_config_one fields
  localparam int G_CRC_EN = 0;
  localparam int G_OUT_EN = 1;
  localparam int G_CUR_MODE = 2;
  localparam int G_MODEM_EN = 3;
  localparam int G_IMM_CLR = 4;
  localparam logic [4:0] GEN_RESET = 5'h01;

  // Slew configuration fields
  localparam int S_EN = 0;
  localparam int S_RATE_LO = 1;
  localparam int S_STEP_LO = 4;
  localparam logic [6:0] SLEW_RESET = 7'h00;

  // Status bits, sticky, write one to clear
  localparam int ST_COUNT = 0;
  localparam int ST_SLIP = 1;
  localparam int ST_CRC = 2;
  localparam int ST_OPEN = 3;
  localparam int ST_DONE = 4;
  localparam int ST_W = 5;
  localparam logic [ST_W-1:0] STATUS_RESET = 5'h00;
  localparam logic [ST_W-1:0] MASK_RESET = 5'h00;

  // Slew update rates in Hz and step sizes in code LSBs
  localparam int unsigned SLEW_FREQ_HZ [8] = '{160000, 80000, 64000, 40000,
                                               32000, 16000, 8000, 4000};
  localparam int unsigned SLEW_STEP_LSB [8] = '{1, 2, 4, 16, 32, 64, 128, 256};
  localparam int TICK_W = 12;

  function automatic logic [TICK_W-1:0] rate_cycles(input logic [2:0] sel);
    rate_cycles = TICK_W'(CLK_HZ / SLEW_FREQ_HZ[sel]);
  endfunction

  function automatic logic [CODE_W-1:0] step_lsb(input logic [2:0] sel);
    step_lsb = CODE_W'(SLEW_STEP_LSB[sel]);
  endfunction
endpackage

// file: hdl/swsc_slew_if.sv
/*
  Interface between the frame front end and the slew engine.
  Assumes both ends run on clk_sys; strobes are one cycle long.
*/
`timescale 1ns/1ps
interface swsc_slew_if;
  logic [15:0] target;
  logic load;
  logic [15:0] clear_code;
  logic clear;
  logic slew_en;
  logic imm_clear;
  logic [2:0] rate_sel;
  logic [2:0] step_sel;
  logic [15:0] code;

  modport ctl (output target, load, clear_code, clear, slew_en, imm_clear,
               rate_sel, step_sel, input code);
  modport eng (input target, load, clear_code, clear, slew_en, imm_clear,
               rate_sel, step_sel, output code);
endinterface

// file: hdl/swsc_slew.sv
/*
  Slew engine: moves the output code toward the goal in steps at the
  selected update rate, or jumps when slewing is off or clear is immediate.
  Assumes strobes from swsc_slew_if.ctl on the same clock.
*/
`timescale 1ns/1ps
module swsc_slew
  import swsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control side
  swsc_slew_if.eng sif
);
  logic [15:0] code_reg, code_next;
  logic [15:0] goal_reg, goal_next;
  logic [TICK_W-1:0] div_reg, div_next;
  logic tick;
  logic [15:0] step;

  // Rate divider; period set by rate_sel alone
  always_comb begin
    tick = (div_reg >= rate_cycles(sif.rate_sel) - 1'b1);
    div_next = tick ? '0 : div_reg + 1'b1;
  end

  // Goal and code update
  always_comb begin
    step = step_lsb(sif.step_sel);
    goal_next = goal_reg;
    code_next = code_reg;
    if (sif.clear) begin
      goal_next = sif.clear_code;
      // Immediate clear or slew off bypasses stepping; otherwise clear slews too
      if (sif.imm_clear || !sif.slew_en) code_next = sif.clear_code;
    end else if (sif.load) begin
      goal_next = sif.target;
      if (!sif.slew_en) code_next = sif.target;
    end else if (!sif.slew_en) begin
      code_next = goal_reg;
    end else if (tick && code_reg != goal_reg) begin
      // Clamp to goal so the last step never overshoots
      if (code_reg < goal_reg) begin
        code_next = (goal_reg - code_reg <= step) ? goal_reg : code_reg + step;
      end else begin
        code_next = (code_reg - goal_reg <= step) ? goal_reg : code_reg - step;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      code_reg <= 16'h0000;
      goal_reg <= 16'h0000;
      div_reg <= '0;
    end else begin
      code_reg <= code_next;
      goal_reg <= goal_next;
      div_reg <= div_next;
    end
  end

  assign sif.code = code_reg;

  property p_direct_load;
    @(posedge clk_sys) disable iff (sys_rst)
    (sif.load && !sif.clear && !sif.slew_en) |=> (code_reg == $past(sif.target));
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("direct load missed");

  property p_step_bound;
    @(posedge clk_sys) disable iff (sys_rst)
    (tick && sif.slew_en && !sif.load && !sif.clear && code_reg < goal_reg) |=>
      (code_reg <= goal_reg && code_reg - $past(code_reg) <= $past(step));
  endproperty
  a_step_bound: assert property (p_step_bound) else $error("step overshoot");

  property p_imm_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    (sif.clear && sif.imm_clear) |=> (code_reg == $past(sif.clear_code));
  endproperty
  a_imm_clear: assert property (p_imm_clear) else $error("immediate clear missed");

  property p_clear_slews;
    @(posedge clk_sys) disable iff (sys_rst)
    (sif.clear && sif.slew_en && !sif.imm_clear) |=> (code_reg == $past(code_reg));
  endproperty
  a_clear_slews: assert property (p_clear_slews) else $error("clear jumped");

  sequence s_quiet;
    !tick [*8];
  endsequence
  property p_tick_gap;
    @(posedge clk_sys) disable iff (sys_rst)
    (tick && $stable(sif.rate_sel)) |=> s_quiet;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
endmodule

// file: hdl/swsc_top.sv
/*
  Serial write front end with slew control, modem coupling gate and
  open-circuit flag. Serial pins come from another clock domain and are
  synchronised here; the local register port is on clk_sys.
*/
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module swsc_top
  import swsc_pkg::*;
#(
  parameter int DATA_W = 16
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic board_address_pin_low,
  input wire logic board_address_pin_high,
  // Analog status and events
  input wire logic headroom_low,
  input wire logic clear_req,
  // Local register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Outputs
  output logic [15:0] dac_code,
  output logic modem_route_en,
  output logic fault_n,
  output logic irq
);
  if (DATA_W != CODE_W) begin : g_chk
    $error("DATA_W must equal the 16-bit frame data field");
  end

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    crc8 = c;
  endfunction

  // Pin synchronisers; stage one feeds only stage two
  logic [2:0] sclk_s, sync_s;
  logic [1:0] sdi_s, ba_lo_s, ba_hi_s, hr_s;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_s <= 3'h7; // Link clock idles high, so no false edge follows reset
      sync_s <= 3'h7;
      sdi_s <= 2'h0;
      ba_lo_s <= 2'h0;
      ba_hi_s <= 2'h0;
      hr_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      sync_s <= {sync_s[1:0], sync_n};
      sdi_s <= {sdi_s[0], sdi};
      ba_lo_s <= {ba_lo_s[0], board_address_pin_low};
      ba_hi_s <= {ba_hi_s[0], board_address_pin_high};
      hr_s <= {hr_s[0], headroom_low};
    end
  end

  logic fall, frame_end;
  assign fall = sclk_s[2] & ~sclk_s[1] & ~sync_s[1];
  assign frame_end = ~sync_s[2] & sync_s[1];

  // Serial shift state
  logic [31:0] sr_reg, sr_next;
  logic [5:0] cnt_reg, cnt_next;
  always_comb begin
    sr_next = sr_reg;
    cnt_next = cnt_reg;
    if (frame_end) begin
      cnt_next = 6'h00;
    end else if (fall) begin
      sr_next = {sr_reg[30:0], sdi_s[1]};
      if (cnt_reg != 6'h3f) cnt_next = cnt_reg + 6'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sr_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
    end else begin
      sr_reg <= sr_next;
      cnt_reg <= cnt_next;
    end
  end

  // Frame checks
  logic [4:0] gen_reg, gen_next;
  logic [31:0] frame;
  logic len_ok, addr_ok, slip_ok, crc_ok, commit;
  logic ev_count, ev_slip, ev_crc;
  always_comb begin
    // Short frame is left-aligned so field positions stay fixed
    frame = (cnt_reg == 6'(FRAME_SHORT)) ? {sr_reg[23:0], 8'h00} : sr_reg;
    len_ok = gen_reg[G_CRC_EN] ? (cnt_reg == 6'(FRAME_LONG)) :
             (cnt_reg == 6'(FRAME_SHORT) || cnt_reg == 6'(FRAME_LONG));
    addr_ok = frame[F_BADDR_HI:F_BADDR_LO] == {ba_hi_s[1], ba_lo_s[1]};
    slip_ok = frame[F_CHECK] == ~frame[F_BADDR_HI];
    crc_ok = !gen_reg[G_CRC_EN] || crc8(frame[31:8]) == frame[7:0];
    // Count errors flag regardless of address; others only for this board
    ev_count = frame_end && !len_ok;
    ev_slip = frame_end && len_ok && addr_ok && !slip_ok;
    ev_crc = frame_end && len_ok && addr_ok && slip_ok && !crc_ok;
    commit = frame_end && len_ok && addr_ok && slip_ok && crc_ok;
  end

  // Configuration, status and port state
  logic [6:0] slew_reg, slew_next;
  logic [15:0] target_reg, target_next, clr_reg, clr_next;
  logic [ST_W-1:0] status_reg, status_next, mask_reg, mask_next, events;
  logic [31:0] last_reg, last_next, rdata_reg, rdata_next;
  logic load_reg, load_next, clear_reg, clear_next, commit_reg;
  logic irq_reg, irq_next, fault_reg, fault_next, modem_reg, modem_next;
  logic open_ev;
  logic [4:0] ra;
  logic [15:0] fd;
  logic wr_gen, wr_slew, wr_tgt, wr_clr;
  // Slew engine link; declared here because the read mux below uses it
  swsc_slew_if sif ();

  // Event collection and register writes; bus write wins over a frame
  always_comb begin
    ra = frame[F_RADDR_HI:F_RADDR_LO];
    fd = frame[F_DATA_HI:F_DATA_LO];
    open_ev = hr_s[1] && gen_reg[G_CUR_MODE] && gen_reg[G_OUT_EN];
    events = '0;
    events[ST_COUNT] = ev_count;
    events[ST_SLIP] = ev_slip;
    events[ST_CRC] = ev_crc;
    events[ST_OPEN] = open_ev;
    events[ST_DONE] = commit;
    wr_gen = reg_wr && reg_addr == OFS_GEN;
    wr_slew = reg_wr && reg_addr == OFS_SLEW;
    wr_tgt = reg_wr && reg_addr == OFS_TARGET;
    wr_clr = reg_wr && reg_addr == OFS_CLEAR;
    gen_next = wr_gen ? reg_wdata[4:0] : (commit && ra == RA_GEN) ? fd[4:0] : gen_reg;
    slew_next = wr_slew ? reg_wdata[6:0] : (commit && ra == RA_SLEW) ? fd[6:0] : slew_reg;
    target_next = wr_tgt ? reg_wdata[15:0] : (commit && ra == RA_TARGET) ? fd : target_reg;
    clr_next = wr_clr ? reg_wdata[15:0] : (commit && ra == RA_CLEAR) ? fd : clr_reg;
    load_next = wr_tgt || (commit && ra == RA_TARGET);
    clear_next = clear_req;
    last_next = commit ? frame : last_reg;
    mask_next = (reg_wr && reg_addr == OFS_MASK) ? reg_wdata[ST_W-1:0] : mask_reg;
    // Set wins over a same-cycle write-one clear
    status_next = status_reg;
    if (reg_wr && reg_addr == OFS_STATUS) status_next = status_reg & ~reg_wdata[ST_W-1:0];
    status_next = status_next | events;
    irq_next = |(status_next & mask_next);
    fault_next = !status_next[ST_OPEN];
    modem_next = gen_next[G_MODEM_EN] && gen_next[G_OUT_EN];
  end

  // Read data, valid only in the cycle after the read strobe
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_GEN: rdata_next = {27'h0, gen_reg};
        OFS_SLEW: rdata_next = {25'h0, slew_reg};
        OFS_TARGET: rdata_next = {16'h0, target_reg};
        OFS_CLEAR: rdata_next = {16'h0, clr_reg};
        OFS_STATUS: rdata_next = {27'h0, status_reg};
        OFS_MASK: rdata_next = {27'h0, mask_reg};
        OFS_CODE: rdata_next = {16'h0, sif.code};
        OFS_FRAME: rdata_next = last_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gen_reg <= GEN_RESET;
      slew_reg <= SLEW_RESET;
      target_reg <= 16'h0000;
      clr_reg <= 16'h0000;
      status_reg <= STATUS_RESET;
      mask_reg <= MASK_RESET;
      last_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
      load_reg <= 1'b0;
      clear_reg <= 1'b0;
      commit_reg <= 1'b0;
      irq_reg <= 1'b0;
      fault_reg <= 1'b1;
      modem_reg <= 1'b0;
    end else begin
      gen_reg <= gen_next;
      slew_reg <= slew_next;
      target_reg <= target_next;
      clr_reg <= clr_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      last_reg <= last_next;
      rdata_reg <= rdata_next;
      load_reg <= load_next;
      clear_reg <= clear_next;
      commit_reg <= commit;
      irq_reg <= irq_next;
      fault_reg <= fault_next;
      modem_reg <= modem_next;
    end
  end

  // Slew engine hookup
  assign sif.target = target_reg;
  assign sif.load = load_reg;
  assign sif.clear_code = clr_reg;
  assign sif.clear = clear_reg;
  assign sif.slew_en = slew_reg[S_EN];
  assign sif.imm_clear = gen_reg[G_IMM_CLR];
  assign sif.rate_sel = slew_reg[S_RATE_LO +: 3];
  assign sif.step_sel = slew_reg[S_STEP_LO +: 3];

  swsc_slew u_slew (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sif(sif)
  );

  assign reg_rdata = rdata_reg;
  assign dac_code = sif.code;
  assign modem_route_en = modem_reg;
  assign fault_n = fault_reg;
  assign irq = irq_reg;

  property p_shift;
    @(posedge clk_sys) disable iff (sys_rst)
    (fall && !frame_end) |=> (sr_reg == {$past(sr_reg[30:0]), $past(sdi_s[1])});
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");

  property p_crc_default;
    @(posedge clk_sys) $fell(sys_rst) |-> gen_reg[G_CRC_EN];
  endproperty
  a_crc_default: assert property (p_crc_default) else $error("crc off after reset");

  property p_short_ok;
    @(posedge clk_sys) disable iff (sys_rst)
    (frame_end && !gen_reg[G_CRC_EN] && cnt_reg == 6'(FRAME_SHORT) && addr_ok && slip_ok)
      |=> commit_reg;
  endproperty
  a_short_ok: assert property (p_short_ok) else $error("short frame lost");

  property p_addr;
    @(posedge clk_sys) disable iff (sys_rst)
    (frame_end && !addr_ok) |=> (!commit_reg && !status_reg[ST_SLIP] == !$past(status_reg[ST_SLIP]));
  endproperty
  a_addr: assert property (p_addr) else $error("foreign frame taken");

  property p_crc_bad;
    @(posedge clk_sys) disable iff (sys_rst)
    (frame_end && len_ok && addr_ok && slip_ok && gen_reg[G_CRC_EN] &&
     crc8(frame[31:8]) != frame[7:0]) |=> (!commit_reg && status_reg[ST_CRC]);
  endproperty
  a_crc_bad: assert property (p_crc_bad) else $error("bad crc committed");

  property p_slip;
    @(posedge clk_sys) disable iff (sys_rst)
    (frame_end && len_ok && addr_ok && frame[31] == frame[30]) |=>
      (!commit_reg && status_reg[ST_SLIP]);
  endproperty
  a_slip: assert property (p_slip) else $error("slip not caught");

  property p_count;
    @(posedge clk_sys) disable iff (sys_rst)
    (frame_end && cnt_reg != 6'(FRAME_LONG) && cnt_reg != 6'(FRAME_SHORT)) |=>
      (!commit_reg && status_reg[ST_COUNT]);
  endproperty
  a_count: assert property (p_count) else $error("count error missed");

  sequence s_open_fault;
    status_reg[ST_OPEN] && !fault_n;
  endsequence
  property p_open;
    @(posedge clk_sys) disable iff (sys_rst)
    (hr_s[1] && gen_reg[G_CUR_MODE] && gen_reg[G_OUT_EN]) |=> s_open_fault;
  endproperty
  a_open: assert property (p_open) else $error("open circuit missed");

  property p_modem;
    @(posedge clk_sys) disable iff (sys_rst)
    modem_route_en |-> (gen_reg[G_MODEM_EN] && gen_reg[G_OUT_EN]);
  endproperty
  a_modem: assert property (p_modem) else $error("modem gated wrong");
endmodule

// file: verification/swsc_master.sv
/*
  Serial bus master model for the write front end: shifts frames MSB first.
  Assumes an 800 ns link clock that stands high between frames and no pull on the data line.
*/
`timescale 1ns/1ps
module swsc_master (
  // Serial pins
  output logic sclk,
  output logic sync_n,
  output logic sdi
);
  // Idle bus: clock parked high, no frame selected
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
  end

  // Top n bits go out MSB first, set while the clock is high so each fall samples a settled bit
  task automatic send(input logic [31:0] f, input int n);
    int i;
    // Start off the clk_sys edge so no pin moves where it is sampled
    #7 sync_n = 1'b0;
    for (i = 31; i > 31 - n; i--) begin
      sdi = f[i];
      #400 sclk = 1'b0;
      #400 sclk = 1'b1;
    end
    #400 sync_n = 1'b1;
    // Released line has no pull, so show the inverse rather than a stale bit
    sdi = ~sdi;
    #1000;
  endtask
endmodule

// file: verification/swsc_top_tb.sv
/*
  Self-checking bench for swsc_top: serial frames, register port, slew, clear and fault flag.
  Assumes swsc_master as the far side and a 10 MHz clk_sys.
*/
`timescale 1ns/1ps
module swsc_top_tb;
  import swsc_pkg::*;
  logic clk_sys, sys_rst, sclk, sync_n, sdi, headroom_low, clear_req, reg_wr, reg_rd;
  logic board_address_pin_low, board_address_pin_high, modem_route_en, fault_n, irq;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, f, rd;
  logic [15:0] dac_code, d;
  logic [1:0] board;
  int fail_count, checks, m_code, r;

  // System clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  swsc_top #(.DATA_W(16)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
    .board_address_pin_low(board_address_pin_low),
    .board_address_pin_high(board_address_pin_high),
    .headroom_low(headroom_low), .clear_req(clear_req), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dac_code(dac_code), .modem_route_en(modem_route_en), .fault_n(fault_n), .irq(irq)
  );

  swsc_master mst (.sclk(sclk), .sync_n(sync_n), .sdi(sdi));

  // Value comparison, counted
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Register port cycles: one-cycle strobes launched just after an edge
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Status is read, compared, then cleared by writing ones
  task automatic check_status(input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(OFS_STATUS, v);
    chk("status", exp, v);
    wr(OFS_STATUS, 32'h1f);
  endtask

  // Frame builder; bad forces a wrong slip bit under a valid check byte
  function automatic logic [31:0] mk(input logic [1:0] b, input logic [4:0] ra,
                                     input logic [15:0] v, input logic bad);
    logic [23:0] h;
    logic [7:0] c;
    int i;
    h = {1'b0, b, ra, v};
    h[23] = ~h[22] ^ bad;
    c = 8'h00;
    for (i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ h[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return {h, c};
  endfunction

  // Send a frame, then compare the output code and the sticky status
  task automatic send_chk(input logic [31:0] fr, input int n, input logic [31:0] st);
    mst.send(fr, n);
    repeat (12) @(posedge clk_sys);
    #1 chk("dac_code", 32'(m_code), 32'(dac_code));
    check_status(st);
  endtask

  // Follow a slew to its goal, checking each step and the spacing of ticks
  task automatic watch(input int tgt, input int step, input int per);
    int cur, last, c, e;
    #1 cur = dac_code;
    last = -1;
    for (c = 0; c < 12 * per && cur != tgt; c++) begin
      @(posedge clk_sys);
      #1;
      if (dac_code !== 16'(cur)) begin
        e = (tgt > cur) ? cur + ((tgt - cur < step) ? tgt - cur : step)
                        : cur - ((cur - tgt < step) ? cur - tgt : step);
        chk("slew_code", 32'(e), 32'(dac_code));
        if (last >= 0) chk("slew_period", 32'(per), 32'(c - last));
        last = c;
        cur = dac_code;
      end
    end
    if (cur != tgt) begin
      fail_count++;
      $display("MISMATCH slew_goal expected %h seen %h", tgt, cur);
      report_and_stop();
    end
    m_code = tgt;
  endtask

  task automatic clr_pulse();
    @(posedge clk_sys);
    clear_req <= 1'b1;
    @(posedge clk_sys);
    clear_req <= 1'b0;
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {headroom_low, clear_req, reg_wr, reg_rd} = 4'h0;
    {board_address_pin_low, board_address_pin_high} = 2'h0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    fail_count = 0;
    checks = 0;
    m_code = 0;
    void'($urandom(93431));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd_reg(OFS_GEN, rd);
    chk("gen_reset", 32'h1, rd);
    @(posedge clk_sys);
    #1 chk("rdata_idle", 32'h0, reg_rdata);
    chk("outputs_reset", 32'h2, {dac_code, modem_route_en, fault_n, irq});
    rd_reg(5'h02, rd);
    chk("unmapped", 32'h0, rd);
    $display("Test reset done");

    // Frames with check byte on, slew off: accept, then each kind of refusal
    board = 2'($urandom);
    board_address_pin_high <= board[1];
    board_address_pin_low <= board[0];
    wr(OFS_GEN, 32'h3);
    d = 16'($urandom);
    m_code = d;
    send_chk(mk(board, RA_TARGET, d, 1'b0), 32, 32'h10);
    f = mk(board, RA_TARGET, ~d, 1'b0);
    f[0] = ~f[0];
    send_chk(f, 32, 32'h04);
    send_chk(mk(board, RA_TARGET, ~d, 1'b1), 32, 32'h02);
    send_chk(mk(~board, RA_TARGET, ~d, 1'b0), 32, 32'h00);
    send_chk(mk(board, RA_TARGET, ~d, 1'b0), 31, 32'h01);
    send_chk(mk(board, RA_TARGET, ~d, 1'b0), 24, 32'h01);
    $display("Test frames done");

    // Check byte off by frame: short frames and ignored tails
    send_chk(mk(board, RA_GEN, 16'h0002, 1'b0), 32, 32'h10);
    m_code = 16'h0064;
    send_chk(mk(board, RA_TARGET, 16'h0064, 1'b0), 24, 32'h10);
    f = mk(board, RA_TARGET, 16'h0050, 1'b0);
    f[7:0] = ~f[7:0];
    m_code = 16'h0050;
    send_chk(f, 32, 32'h10);
    send_chk(mk(board, RA_TARGET, 16'h0010, 1'b0), 25, 32'h01);
    wr(OFS_GEN, 32'h3);
    $display("Test short frames done");

    // Slew over every rate and step setting, then down to zero
    for (r = 0; r < 8; r++) begin
      wr(OFS_SLEW, 32'((r << 4) | (r << 1) | 1));
      f = 32'(m_code + 3 * SLEW_STEP_LSB[r] + ((r > 2) ? 5 : 0));
      wr(OFS_TARGET, f);
      watch(int'(f), SLEW_STEP_LSB[r], CLK_HZ / SLEW_FREQ_HZ[r]);
    end
    wr(OFS_SLEW, 32'h71);
    wr(OFS_TARGET, 32'h0);
    watch(0, 256, CLK_HZ / SLEW_FREQ_HZ[0]);
    rd_reg(OFS_CODE, rd);
    chk("code_reg", 32'h0, rd);
    $display("Test slew done");

    // Clear code and slew set by frames; clear slews unless immediate
    send_chk(mk(board, RA_CLEAR, 16'd40, 1'b0), 32, 32'h10);
    send_chk(mk(board, RA_SLEW, 16'h0041, 1'b0), 32, 32'h10);
    rd_reg(OFS_FRAME, rd);
    chk("last_frame", mk(board, RA_SLEW, 16'h0041, 1'b0), rd);
    clr_pulse();
    watch(40, 32, CLK_HZ / SLEW_FREQ_HZ[0]);
    wr(OFS_GEN, 32'h13);
    wr(OFS_CLEAR, 32'd1000);
    clr_pulse();
    repeat (3) @(posedge clk_sys);
    #1 chk("clear_now", 32'd1000, 32'(dac_code));
    $display("Test clear done");

    // Modem routing needs both coupling enable and output enable
    for (r = 0; r < 4; r++) begin
      wr(OFS_GEN, 32'(1 | (r[0] << 1) | (r[1] << 3)));
      repeat (2) @(posedge clk_sys);
      #1 chk("modem_route_en", 32'(r == 3), 32'(modem_route_en));
    end
    $display("Test modem done");

    // Headroom loss flags only in current mode; interrupt raised, masked, cleared
    wr(OFS_MASK, 32'(1 << ST_OPEN));
    for (r = 0; r < 2; r++) begin
      wr(OFS_GEN, (r == 1) ? 32'h07 : 32'h03);
      headroom_low <= 1'b1;
      repeat (8) @(posedge clk_sys);
      #1 chk("fault_n", 32'(r == 0), 32'(fault_n));
      chk("irq", 32'(r), 32'(irq));
      wr(OFS_MASK, 32'h0);
      repeat (2) @(posedge clk_sys);
      #1 chk("irq_masked", 32'h0, 32'(irq));
      wr(OFS_MASK, 32'(1 << ST_OPEN));
      headroom_low <= 1'b0;
      repeat (5) @(posedge clk_sys);
      check_status((r == 1) ? 32'h08 : 32'h00);
      repeat (3) @(posedge clk_sys);
      #1 chk("fault_clear", 32'h2, {fault_n, irq});
    end
    $display("Test open circuit done");
    report_and_stop();
  end
endmodule
